// >>> hw/ppc_pkg.sv
/*
 * Shared constants, types and helpers for the port pad configuration
 * block: register offsets, reset values, field layout and codes.
 * Assumes a 32-bit register port addressed in bytes, 16 pins per port.
 */
package ppc_pkg;

    localparam int PINS    = 16;
    localparam int FIELD_W = 2;

    // byte offsets of the word registers
    localparam logic [7:0] OFS_DRV  = 8'h04;
    localparam logic [7:0] OFS_RATE = 8'h08;
    localparam logic [7:0] OFS_BIAS = 8'h0c;
    localparam logic [7:0] OFS_LVL  = 8'h10;

    // reset values
    localparam logic [15:0] DRV_RST     = 16'h0000;
    localparam logic [31:0] RATE_RST_A  = 32'h0c00_0000;
    localparam logic [31:0] RATE_RST    = 32'h0000_0000;
    localparam logic [31:0] BIAS_RST_A  = 32'h2400_0000;
    localparam logic [31:0] BIAS_RST    = 32'h0000_0000;
    localparam logic [15:0] RSVD_ZERO   = 16'h0000;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

    // driver type bit values
    localparam logic DRV_PUSH_PULL  = 1'b0;
    localparam logic DRV_OPEN_DRAIN = 1'b1;

    // bias field codes
    localparam logic [1:0] BIAS_FLOAT = 2'h0;
    localparam logic [1:0] BIAS_UP    = 2'h1;
    localparam logic [1:0] BIAS_DOWN  = 2'h2;
    localparam logic [1:0] BIAS_RSVD  = 2'h3;

    // pin synchroniser depth, cycles from pin to readable level
    localparam int SYNC_STAGES = 2;

    // decoded rate handed to the pad, gray along 2M -> 10M -> 50M
    typedef enum logic [1:0] {
        RATE_2M  = 2'h0,
        RATE_10M = 2'h1,
        RATE_50M = 2'h3
    } ppc_rate_t;

    function automatic logic [1:0] ppc_field(input logic [31:0] v,
                                             input int          y);
        return v[FIELD_W*y +: FIELD_W];
    endfunction

    function automatic ppc_rate_t ppc_rate_decode(input logic [1:0] c);
        ppc_rate_t r;
        r = RATE_2M;
        if (c[0])
        begin
            r = c[1] ? RATE_50M : RATE_10M;
        end
        return r;
    endfunction

    function automatic logic [7:0] ppc_word(input logic [7:0] a);
        return {a[7:2], 2'h0};
    endfunction

endpackage

// >>> hw/ppc_cfg_if.sv
/*
 * Configuration carrier from the register file to the pad stage.
 * Assumes both ends run on the same clock; no timing of its own.
 */
`timescale 1ns/1ps
interface ppc_cfg_if;
    logic [15:0] drv;
    logic [31:0] rate;
    logic [31:0] bias;

    modport regs (output drv, output rate, output bias);
    modport pad  (input  drv, input  rate, input  bias);
endinterface

// >>> hw/ppc_pad_stage.sv
/*
 * Pad stage: turns driver type, rate and bias fields into registered
 * per-pin pad controls. Assumes output value and enable come from
 * port logic on the same clock, so they are not synchronised.
 */
`timescale 1ns/1ps
module ppc_pad_stage
    import ppc_pkg::*;
(
    // clock and reset
    input  wire logic  ref_clk_in,
    input  wire logic  reset_in,
    // configuration
    ppc_cfg_if.pad     cfg,
    // pin requests from port logic
    input  wire logic [15:0] out_val_in,
    input  wire logic [15:0] out_en_in,
    // pad controls
    output logic [15:0] pad_out,
    output logic [15:0] pad_oe_out,
    output logic [15:0] pull_up_out,
    output logic [15:0] pull_dn_out,
    output logic [31:0] rate_sel_out
);

    typedef struct packed {
        logic [15:0] o;
        logic [15:0] oe;
        logic [15:0] pu;
        logic [15:0] pd;
        logic [31:0] rate;
    } ppc_pad_state_t;

    ppc_pad_state_t q;
    ppc_pad_state_t d;

    always_comb
    begin
        d = q;
        for (int y = 0; y < PINS; y++)
        begin
            if (cfg.drv[y] == DRV_OPEN_DRAIN)
            begin
                // only ever pull low; high is left to the bus
                d.o[y]  = 1'b0;
                d.oe[y] = out_en_in[y] & ~out_val_in[y];
            end
            else
            begin
                d.o[y]  = out_val_in[y];
                d.oe[y] = out_en_in[y];
            end
            // reserved bias code enables neither pull
            d.pu[y] = ppc_field(cfg.bias, y) == BIAS_UP;
            d.pd[y] = ppc_field(cfg.bias, y) == BIAS_DOWN;
            d.rate[FIELD_W*y +: FIELD_W] =
                ppc_rate_decode(ppc_field(cfg.rate, y));
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign pad_out      = q.o;
    assign pad_oe_out   = q.oe;
    assign pull_up_out  = q.pu;
    assign pull_dn_out  = q.pd;
    assign rate_sel_out = q.rate;

    chk_open_drain_low: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        !reset_in |=> ((pad_out & $past(cfg.drv)) == 16'h0000) &&
        ((pad_oe_out & $past(cfg.drv)) ==
         ($past(out_en_in & ~out_val_in) & $past(cfg.drv))))
        else $error("open-drain pin not driven low only");

    chk_push_pull_drive: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        !reset_in |=> ((pad_out & ~$past(cfg.drv)) ==
             ($past(out_val_in) & ~$past(cfg.drv))) &&
        ((pad_oe_out & ~$past(cfg.drv)) ==
         ($past(out_en_in) & ~$past(cfg.drv))))
        else $error("push-pull pin not following its request");

    chk_rate_pin_zero: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        !reset_in |=> rate_sel_out[1:0] ==
            ($past(cfg.rate[0]) ?
             ($past(cfg.rate[1]) ? 2'h3 : 2'h1) : 2'h0))
        else $error("pin 0 rate decode wrong");

    chk_bias_exclusive: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        !reset_in |=> ((pull_up_out & pull_dn_out) == 16'h0000) &&
        (pull_up_out[15] == ($past(cfg.bias[31:30]) == 2'h1)) &&
        (pull_dn_out[15] == ($past(cfg.bias[31:30]) == 2'h2)))
        else $error("bias pulls wrong or both on");

endmodule

// >>> hw/ppc_port_cfg.sv
/*
 * Port pad configuration top: driver type, drive rate and bias
 * registers, and the synchronised pin level sample, on a plain
 * register port. Assumes a master that holds strobes one cycle,
 * never both at once, and takes read data the cycle after the strobe.
 * Narrow reads take their lanes from the whole aligned word.
 */
// Behaviour
// - driver-type bit one makes the pin open-drain, driving low only
// - driver-type bit zero, the reset state, makes the pin push-pull
// - rate register holds two bits per pin, pin y at 2y+1:2y
// - rate code x0 gives 2 MHz, 01 gives 10 MHz, 11 gives 50 MHz
// - rate register at 0x08 resets 0x0c000000 on port A, else zero
// - bias code 00 floats, 01 pulls up, 10 pulls down, 11 reserved
// - bias register at 0x0c resets 0x24000000 on port A, else zero
// - level bits follow sampled pins only; software writes ignored
// - level register readable by byte, half-word or word accesses
// - level register at 0x10 reads zero in its upper sixteen bits
`timescale 1ns/1ps
module ppc_port_cfg
    import ppc_pkg::*;
#(
    parameter bit IS_PORT_A = 1'b0
)
(
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        reset_in,
    // register port
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    // pins
    input  wire logic [15:0] pin_in,
    // requests from port output logic
    input  wire logic [15:0] out_val_in,
    input  wire logic [15:0] out_en_in,
    // pad controls
    output logic      [15:0] pad_out,
    output logic      [15:0] pad_oe_out,
    output logic      [15:0] pull_up_out,
    output logic      [15:0] pull_dn_out,
    output logic      [31:0] rate_sel_out
);

    typedef struct packed {
        logic [15:0] drv;
        logic [31:0] rate;
        logic [31:0] bias;
        logic [15:0] sync1;
        logic [15:0] lvl;
        logic [31:0] rdata;
    } ppc_top_state_t;

    // reset image chosen per instance, not per write
    localparam logic [31:0] RATE_INIT =
        IS_PORT_A ? RATE_RST_A : RATE_RST;
    localparam logic [31:0] BIAS_INIT =
        IS_PORT_A ? BIAS_RST_A : BIAS_RST;

    localparam ppc_top_state_t TOP_RST = '{
        drv:   DRV_RST,
        rate:  RATE_INIT,
        bias:  BIAS_INIT,
        sync1: 16'h0000,
        lvl:   16'h0000,
        rdata: 32'h0000_0000
    };

    ppc_top_state_t q;
    ppc_top_state_t d;
    logic [7:0]     word;

    ppc_cfg_if cfg ();

    assign word = ppc_word(addr_in);

    always_comb
    begin
        d = q;
        // two flops before anyone looks at the pins
        d.sync1 = pin_in;
        d.lvl   = q.sync1;
        d.rdata = 32'h0000_0000;

        if (wr_in)
        begin
            unique case (word)
                OFS_DRV:
                begin
                    d.drv = wdata_in[15:0];
                end
                OFS_RATE:
                begin
                    d.rate = wdata_in;
                end
                OFS_BIAS:
                begin
                    d.bias = wdata_in;
                end
                default:
                begin
                    // level word is hardware-owned; writes fall away
                    d.drv = q.drv;
                end
            endcase
        end

        if (rd_in)
        begin
            unique case (word)
                OFS_DRV:
                begin
                    d.rdata = {RSVD_ZERO, q.drv};
                end
                OFS_RATE:
                begin
                    d.rdata = q.rate;
                end
                OFS_BIAS:
                begin
                    d.rdata = q.bias;
                end
                OFS_LVL:
                begin
                    // whole word returned; narrow reads pick lanes
                    d.rdata = {RSVD_ZERO, q.lvl};
                end
                default:
                begin
                    d.rdata = UNMAPPED_RD;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            q <= TOP_RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign cfg.drv   = q.drv;
    assign cfg.rate  = q.rate;
    assign cfg.bias  = q.bias;
    assign rdata_out = q.rdata;

    ppc_pad_stage u_pad (
        .ref_clk_in   (ref_clk_in),
        .reset_in     (reset_in),
        .cfg          (cfg.pad),
        .out_val_in   (out_val_in),
        .out_en_in    (out_en_in),
        .pad_out      (pad_out),
        .pad_oe_out   (pad_oe_out),
        .pull_up_out  (pull_up_out),
        .pull_dn_out  (pull_dn_out),
        .rate_sel_out (rate_sel_out)
    );

    // helper: cycles since reset release, saturating at three
    logic [1:0] age_q;

    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            age_q <= 2'h0;
        end
        else if (age_q != 2'h3)
        begin
            age_q <= age_q + 2'h1;
        end
    end

    sequence s_wr_rate;
        wr_in && (word == OFS_RATE);
    endsequence

    sequence s_wr_bias;
        wr_in && (word == OFS_BIAS);
    endsequence

    sequence s_rd_lvl;
        rd_in && (word == OFS_LVL);
    endsequence

    chk_rate_field_map: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        s_wr_rate ##1 !wr_in |=>
            rate_sel_out[31:30] == ppc_rate_decode($past(wdata_in[31:30],
                2)) &&
            rate_sel_out[1:0] == ppc_rate_decode($past(wdata_in[1:0], 2)))
        else $error("rate field not at its pin position");

    // master leaves at least one idle cycle between write and read
    chk_rate_readback: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        s_wr_rate ##1 !wr_in ##1 (rd_in && word == OFS_RATE && !wr_in) |=>
            rdata_out == $past(wdata_in, 3))
        else $error("rate register readback wrong");

    chk_rate_reset_value: assert property (
        @(posedge ref_clk_in)
        reset_in ##1 !reset_in ##1 (rd_in && word == OFS_RATE && !wr_in)
            |=> rdata_out == RATE_INIT)
        else $error("rate register reset value wrong");

    // port A pin 13 resets to code 11, the fastest rate
    chk_rate_slow_reset: assert property (
        @(posedge ref_clk_in)
        reset_in ##1 !reset_in |=>
            rate_sel_out[25:24] == 2'h0 &&
            rate_sel_out[27:26] == (IS_PORT_A ? 2'h3 : 2'h0))
        else $error("rate decode after reset wrong");

    chk_bias_reset_value: assert property (
        @(posedge ref_clk_in)
        reset_in ##1 !reset_in |=>
            pull_up_out[13] == IS_PORT_A &&
            pull_dn_out[14] == IS_PORT_A &&
            pull_up_out[12:0] == 13'h0000)
        else $error("bias reset value wrong");

    chk_bias_readback: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        s_wr_bias ##1 !wr_in ##1 (rd_in && word == OFS_BIAS && !wr_in) |=>
            rdata_out == $past(wdata_in, 3))
        else $error("bias register readback wrong");

    chk_level_follows_pin: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        s_rd_lvl and (age_q == 2'h3) |=>
            rdata_out[15:0] == $past(pin_in, 3))
        else $error("level bits not following the pins");

    chk_level_write_ignored: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        (wr_in && word == OFS_LVL) |=> q.lvl == $past(q.sync1) &&
            q.drv == $past(q.drv) && q.rate == $past(q.rate))
        else $error("write to level register had an effect");

    chk_level_byte_lane: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        (rd_in && addr_in == (OFS_LVL | 8'h01)) |=>
            rdata_out[15:8] == $past(q.lvl[15:8]))
        else $error("byte read of level register wrong lane");

    chk_level_upper_zero: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        s_rd_lvl |=> rdata_out[31:16] == RSVD_ZERO)
        else $error("level register upper bits not zero");

    chk_unmapped_zero: assert property (
        @(posedge ref_clk_in) disable iff (reset_in)
        (rd_in && word > OFS_LVL) ##1 !rd_in |-> rdata_out == 32'h0 ##1
            rdata_out == 32'h0)
        else $error("unmapped read not zero");

endmodule

// >>> verif/testbench.sv
/*
 * Self-checking bench for the port pad configuration block: a port A
 * instance and an other-port instance share one register port and pins.
 * Assumes the package, the carrier interface and the design modules
 * are compiled before this file.
 */
`timescale 1ns/1ps
module testbench
    import ppc_pkg::*;
;
    logic        ref_clk_in = 1'b0;
    logic        reset_in;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] pin;
    logic [15:0] out_val;
    logic [15:0] out_en;
    logic [31:0] rdata    [2];
    logic [15:0] pad      [2];
    logic [15:0] pad_oe   [2];
    logic [15:0] pull_up  [2];
    logic [15:0] pull_dn  [2];
    logic [31:0] rate_sel [2];
    int          bad_count   = 0;
    int          check_count = 0;
    int          cycles      = 0;

    // index 0 carries the port A reset images
    for (genvar g = 0; g < 2; g++)
    begin : port_g
        ppc_port_cfg #(
            .IS_PORT_A    (g == 0)
        ) ppc_port_cfg_i (
            .ref_clk_in   (ref_clk_in),
            .reset_in     (reset_in),
            .addr_in      (addr),
            .wdata_in     (wdata),
            .wr_in        (wr),
            .rd_in        (rd),
            .rdata_out    (rdata[g]),
            .pin_in       (pin),
            .out_val_in   (out_val),
            .out_en_in    (out_en),
            .pad_out      (pad[g]),
            .pad_oe_out   (pad_oe[g]),
            .pull_up_out  (pull_up[g]),
            .pull_dn_out  (pull_dn[g]),
            .rate_sel_out (rate_sel[g])
        );
    end

    always #20 ref_clk_in = ~ref_clk_in;

    // whole run is about a hundred cycles
    always @(posedge ref_clk_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            results();
        end
    end

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk_in);
        wr    <= 1'b0;
    endtask

    // checks both ports, then that read data falls back to zero
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] ea,
                          input logic [31:0] eb);
        @(posedge ref_clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk_in);
        rd   <= 1'b0;
        #1;
        check("read data port a", rdata[0], ea);
        check("read data other", rdata[1], eb);
        @(posedge ref_clk_in);
        #1;
        check("idle read data", rdata[0] | rdata[1], 32'h0);
    endtask

    task automatic pads(input int i, input logic [15:0] po, oe, up, dn,
                        input logic [31:0] rt);
        check("pad value", {16'h0, pad[i]}, {16'h0, po});
        check("pad enable", {16'h0, pad_oe[i]}, {16'h0, oe});
        check("pull up", {16'h0, pull_up[i]}, {16'h0, up});
        check("pull down", {16'h0, pull_dn[i]}, {16'h0, dn});
        check("rate select", rate_sel[i], rt);
    endtask

    initial
    begin
        reset_in = 1'b1;
        addr     = 8'h00;
        wdata    = 32'h0;
        wr       = 1'b0;
        rd       = 1'b0;
        pin      = 16'h0;
        out_val  = 16'h0;
        out_en   = 16'h0;
        repeat (20) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        reg_rd(OFS_DRV, 32'h0, 32'h0);
        reg_rd(OFS_RATE, 32'h0c00_0000, 32'h0);
        reg_rd(OFS_BIAS, 32'h2400_0000, 32'h0);
        pads(0, 16'h0, 16'h0, 16'h2000, 16'h4000, 32'h0c00_0000);
        pads(1, 16'h0, 16'h0, 16'h0, 16'h0, 32'h0);
        // pin y gets code y mod 4, so every code shows
        reg_wr(OFS_RATE, 32'he4e4_e4e4);
        reg_rd(OFS_RATE, 32'he4e4_e4e4, 32'he4e4_e4e4);
        check("rate decode", rate_sel[0], 32'hc4c4_c4c4);
        reg_wr(OFS_RATE, 32'h4000_0003);
        reg_rd(OFS_RATE, 32'h4000_0003, 32'h4000_0003);
        check("rate ends", rate_sel[1], 32'h4000_0003);
        reg_wr(OFS_RATE, 32'h8000_0002);
        reg_rd(OFS_RATE, 32'h8000_0002, 32'h8000_0002);
        check("rate low zero", rate_sel[0], 32'h0);
        reg_wr(OFS_BIAS, 32'he4e4_e4e4);
        reg_rd(OFS_BIAS, 32'he4e4_e4e4, 32'he4e4_e4e4);
        check("bias up", {16'h0, pull_up[0]}, 32'h2222);
        check("bias down", {16'h0, pull_dn[1]}, 32'h4444);
        reg_wr(OFS_BIAS, 32'h4000_0002);
        reg_rd(OFS_BIAS, 32'h4000_0002, 32'h4000_0002);
        // low byte open drain, high byte push-pull
        out_val <= 16'h5a5a;
        out_en  <= 16'hffff;
        reg_wr(OFS_DRV, 32'hffff_00ff);
        reg_rd(OFS_DRV, 32'h0000_00ff, 32'h0000_00ff);
        for (int i = 0; i < 2; i++)
        begin
            pads(i, 16'h5a00, 16'hffa5, 16'h8000, 16'h0001, 32'h0);
        end
        out_en <= 16'h0f0f;
        repeat (2) @(posedge ref_clk_in);
        #1;
        check("pad enable mix", {16'h0, pad_oe[0]}, 32'h0f05);
        check("pad value mix", {16'h0, pad[1]}, 32'h5a00);
        pin <= 16'ha53c;
        repeat (3) @(posedge ref_clk_in);
        reg_rd(OFS_LVL, 32'h0000_a53c, 32'h0000_a53c);
        reg_wr(OFS_LVL, 32'hffff_ffff);
        reg_rd(OFS_LVL, 32'h0000_a53c, 32'h0000_a53c);
        // narrow reads return the aligned word, lanes picked by master
        reg_rd(8'h11, 32'h0000_a53c, 32'h0000_a53c);
        reg_rd(8'h12, 32'h0000_a53c, 32'h0000_a53c);
        pin <= 16'h5ac3;
        repeat (3) @(posedge ref_clk_in);
        reg_rd(8'h13, 32'h0000_5ac3, 32'h0000_5ac3);
        reg_wr(8'h20, 32'hffff_ffff);
        reg_rd(8'h20, 32'h0, 32'h0);
        reg_rd(OFS_RATE, 32'h8000_0002, 32'h8000_0002);
        // second reset in mid-run restores the images
        @(posedge ref_clk_in);
        reset_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        reg_rd(OFS_RATE, 32'h0c00_0000, 32'h0);
        reg_rd(OFS_BIAS, 32'h2400_0000, 32'h0);
        reg_rd(OFS_DRV, 32'h0, 32'h0);
        results();
    end
endmodule
